// ---- core/rcf_pkg.sv ----
// Constants shared by the rate-of-change-of-frequency stage.
// Assumes a 200 MHz processing clock and frequency words in millihertz.
package rcf_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int MS_NS = 1000000;
   localparam int CYC_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int QUAL_MS = 80;
   localparam int START_DLY_MS = 60;
   localparam int STABLE_MS = 80;

   // ------------------------------------------------------------
   // Setting scales, ranges and defaults
   // ------------------------------------------------------------
   localparam int SLOPE_STEP_MHZPS = 100;
   localparam int DLY_STEP_MS = 10;
   localparam logic [6:0] SLOPE_MIN = 7'h02;
   localparam logic [6:0] SLOPE_MAX = 7'h64;
   localparam logic [6:0] SLOPE_DEF = 7'h32;
   localparam logic [6:0] SLOPE_KNEE = 7'h07;
   localparam logic [9:0] DLY_MIN = 10'h00e;
   localparam logic [9:0] DLY_MAX = 10'h3e8;
   localparam logic [9:0] DLY_DEF = 10'h032;
   localparam logic [9:0] PCT_TRIP = 10'h064;
   localparam logic [9:0] PCT_MAX = 10'h3e7;

   // ------------------------------------------------------------
   // Setting word layout
   // ------------------------------------------------------------
   localparam int SLOPE_LSB = 0;
   localparam int SLOPE_W = 7;
   localparam int TSET_LSB = 8;
   localparam int MINIMUM_OPERATE_DELAY_LSB = 20;
   localparam int DLY_W = 10;
   localparam logic [31:0] SET_DEF = {2'h0, DLY_DEF, 2'h0, DLY_DEF, 1'h0, SLOPE_DEF};

   // ------------------------------------------------------------
   // Register byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_CMD = 8'h04;
   localparam logic [7:0] A_STATUS = 8'h08;
   localparam logic [7:0] A_FREQ = 8'h0c;
   localparam logic [7:0] A_SLOPE = 8'h10;
   localparam logic [7:0] A_START_CNT = 8'h14;
   localparam logic [7:0] A_TRIP_CNT = 8'h18;
   localparam logic [7:0] A_FAULT = 8'h1c;
   localparam logic [7:0] A_ELAPSED = 8'h20;
   localparam logic [7:0] A_GROUP_BASE = 8'h40;

   // ------------------------------------------------------------
   // Control and command fields
   // ------------------------------------------------------------
   localparam int CTRL_GRP_LSB = 0;
   localparam int CTRL_SRC_BIT = 2;
   localparam int CTRL_EVT_LSB = 4;
   localparam logic [31:0] CTRL_RST = 32'h0000_00f0;
   localparam int CMD_CLR_START = 0;
   localparam int CMD_CLR_TRIP = 1;

   typedef enum logic [2:0] {ST_IDLE, ST_PICKED, ST_START, ST_TRIP} rcf_state_e;

endpackage : rcf_pkg

// ---- core/rcf_set_if.sv ----
// Setting-group memory port bundle.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
`default_nettype none
interface rcf_set_if #(parameter int GROUPS = 4);
   logic wr_en;
   logic [$clog2(GROUPS)-1:0] wr_idx;
   logic [31:0] wr_data;
   logic [$clog2(GROUPS)-1:0] act_idx;
   logic [31:0] act_data;
   logic [$clog2(GROUPS)-1:0] rd_idx;
   logic [31:0] rd_data;

   modport mem (input wr_en, wr_idx, wr_data, act_idx, rd_idx, output act_data, rd_data);
   modport ctl (output wr_en, wr_idx, wr_data, act_idx, rd_idx, input act_data, rd_data);
endinterface : rcf_set_if
`default_nettype wire

// ---- core/rcf_set_mem.sv ----
// Setting-group storage with two registered read ports.
// Assumes writes are already range-checked by the owner.
`timescale 1ns/10ps
`default_nettype none
module rcf_set_mem
   import rcf_pkg::*;
#(
   parameter int GROUPS = 4
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Access port
   rcf_set_if.mem port
);

   logic [31:0] mem_r [GROUPS];

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   // Every group starts from the default settings
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < GROUPS; i++)
         begin
            mem_r[i] <= SET_DEF;
         end
      end
      else if (port.wr_en)
      begin
         mem_r[port.wr_idx] <= port.wr_data;
      end
   end

   // Registered read ports
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         port.act_data <= SET_DEF;
         port.rd_data <= 32'h0;
      end
      else
      begin
         port.act_data <= mem_r[port.act_idx];
         port.rd_data <= mem_r[port.rd_idx];
      end
   end

endmodule : rcf_set_mem
`default_nettype wire

// ---- core/rcf_stage.sv ----
// Rate-of-change-of-frequency protection stage.
// Assumes frequency samples in mHz arrive from same-clock logic at a fixed
// rate, and group-select pins come from outside the clock domain.
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Compare absolute slope, sign ignored.
// - Pick up after slope above 80 ms.
// - Start output 60 ms after pick-up.
// - Trip at delay if average slope above.
// - Equal delays give definite-time operation.
// - No release on fluctuation; average from pick-up.
// - Release when stable 80 ms, delay elapsed.
// - Smaller minimum delay gives inverse-time operation.
// - Inverse time = setting times delay / slope.
// - Never trip before minimum delay.
// - Low slope settings get extra time floor.
// - Slope setting 0.2 to 10.0, default 5.0.
// - Delays from 0.14 s, default 0.50 s.
// - Four event enables, default enabled.
// - Present frequency and slope readable.
// - Cumulative start and trip counters.
// - Record maximum slope per fault.
// - Record elapsed delay percent, trip 100.
// - Four setting groups, pin or manual select.
// - Counters clearable on command.
module rcf_stage
   import rcf_pkg::*;
#(
   parameter int CYC_PER_MS_P = CYC_PER_MS,
   parameter int SAMPLES_PER_S = 100,
   parameter int LOW_SET_FLOOR_MS = 200,
   parameter int GROUPS = 4
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Frequency measurement
   input wire logic freq_valid,
   input wire logic [23:0] freq_mhz,
   // Setting group select pins
   input wire logic [$clog2(GROUPS)-1:0] group_pins,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Protection outputs
   output logic start_out,
   output logic trip_out,
   output logic start_on_evt,
   output logic start_off_evt,
   output logic trip_on_evt,
   output logic trip_off_evt
);

   localparam int GW = $clog2(GROUPS);

   rcf_set_if #(.GROUPS(GROUPS)) set_bus ();

   rcf_set_mem #(.GROUPS(GROUPS)) u_mem
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .port(set_bus.mem)
   );

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   rcf_state_e state_r;
   logic [31:0] ctrl_r;
   logic [31:0] rdata_r;
   logic rd_grp_r;
   logic [17:0] div_r;
   logic tick;
   logic [GW-1:0] pins_s1_r;
   logic [GW-1:0] pins_s2_r;
   logic [23:0] freq_prev_r;
   logic have_prev_r;
   logic [31:0] slope_r;
   logic sample_stb_r;
   logic [31:0] abs_slope;
   logic [31:0] set_mhzps;
   logic [13:0] tset_ms;
   logic [13:0] minimum_operate_delay_ms;
   logic [13:0] floor_ms;
   logic above;
   logic [6:0] qual_ms_r;
   logic [6:0] stable_ms_r;
   logic [13:0] since_ms_r;
   logic [47:0] sum_r;
   logic [15:0] cnt_r;
   logic avg_above;
   logic inv_due;
   logic trip_cond;
   logic pick_now;
   logic start_now;
   logic release_now;
   logic [31:0] fault_max_r;
   logic [9:0] pct_r;
   logic [13:0] pct_acc_r;
   logic [31:0] start_cnt_r;
   logic [31:0] trip_cnt_r;
   logic grp_hit;
   logic [GW-1:0] grp_idx;

   // ------------------------------------------------------------
   // Millisecond tick divider
   // ------------------------------------------------------------
   // One-cycle enable once per millisecond
   always_ff @(posedge ref_clk)
   begin
      if (rst || tick)
      begin
         div_r <= 18'h0;
      end
      else
      begin
         div_r <= div_r + 18'h1;
      end
   end

   assign tick = (div_r == 18'(CYC_PER_MS_P - 1));

   // ------------------------------------------------------------
   // Group selection
   // ------------------------------------------------------------
   // Two-flop synchroniser for the select pins
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         pins_s1_r <= '0;
         pins_s2_r <= '0;
      end
      else
      begin
         pins_s1_r <= group_pins;
         pins_s2_r <= pins_s1_r;
      end
   end

   // Pins or manual choice pick the live group
   assign set_bus.act_idx = ctrl_r[CTRL_SRC_BIT] ? pins_s2_r : ctrl_r[CTRL_GRP_LSB +: GW];

   // Active settings scaled to mHz/s and ms
   assign set_mhzps = 32'(set_bus.act_data[SLOPE_LSB +: SLOPE_W]) * 32'(SLOPE_STEP_MHZPS);
   assign tset_ms = 14'(32'(set_bus.act_data[TSET_LSB +: DLY_W]) * 32'(DLY_STEP_MS));
   assign minimum_operate_delay_ms = 14'(32'(set_bus.act_data[MINIMUM_OPERATE_DELAY_LSB +: DLY_W]) * 32'(DLY_STEP_MS));
   // Sensitive settings get a slower fastest time
   assign floor_ms = (set_bus.act_data[SLOPE_LSB +: SLOPE_W] < SLOPE_KNEE) ? 14'(LOW_SET_FLOOR_MS) : 14'h0;

   // ------------------------------------------------------------
   // Slope measurement
   // ------------------------------------------------------------
   // Difference of successive samples scaled by the fixed rate
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         freq_prev_r <= 24'h0;
         have_prev_r <= 1'b0;
         slope_r <= 32'h0;
         sample_stb_r <= 1'b0;
      end
      else
      begin
         sample_stb_r <= freq_valid && have_prev_r;
         if (freq_valid)
         begin
            freq_prev_r <= freq_mhz;
            have_prev_r <= 1'b1;
            if (have_prev_r)
            begin
               slope_r <= 32'(($signed({8'h0, freq_mhz}) - $signed({8'h0, freq_prev_r})) * SAMPLES_PER_S);
            end
         end
      end
   end

   // Sign dropped before comparison
   assign abs_slope = slope_r[31] ? (32'h0 - slope_r) : slope_r;
   assign above = abs_slope > set_mhzps;

   // ------------------------------------------------------------
   // Qualification and stability timers
   // ------------------------------------------------------------
   // Continuous-above timer while idle
   always_ff @(posedge ref_clk)
   begin
      if (rst || !above || state_r != ST_IDLE)
      begin
         qual_ms_r <= 7'h0;
      end
      else if (tick && qual_ms_r < 7'(QUAL_MS))
      begin
         qual_ms_r <= qual_ms_r + 7'h1;
      end
   end

   // Continuous-stable timer while picked up
   always_ff @(posedge ref_clk)
   begin
      if (rst || above || state_r == ST_IDLE)
      begin
         stable_ms_r <= 7'h0;
      end
      else if (tick && stable_ms_r < 7'(STABLE_MS))
      begin
         stable_ms_r <= stable_ms_r + 7'h1;
      end
   end

   // Time since pick-up
   always_ff @(posedge ref_clk)
   begin
      if (rst || state_r == ST_IDLE)
      begin
         since_ms_r <= 14'h0;
      end
      else if (tick && since_ms_r != 14'h3fff)
      begin
         since_ms_r <= since_ms_r + 14'h1;
      end
   end

   // ------------------------------------------------------------
   // Average slope since pick-up
   // ------------------------------------------------------------
   // Sum and count kept from the first pick-up instant
   always_ff @(posedge ref_clk)
   begin
      if (rst || state_r == ST_IDLE)
      begin
         sum_r <= 48'h0;
         cnt_r <= 16'h0;
      end
      else if (sample_stb_r && state_r != ST_TRIP && cnt_r != 16'hffff)
      begin
         sum_r <= sum_r + 48'(abs_slope);
         cnt_r <= cnt_r + 16'h1;
      end
   end

   // Average above setting, compared without division
   assign avg_above = (cnt_r != 16'h0) && (sum_r > 48'(64'(set_mhzps) * 64'(cnt_r)));
   // Elapsed time reached setting * delay / average
   assign inv_due = 64'(since_ms_r) * 64'(sum_r) >= 64'(set_mhzps) * 64'(tset_ms) * 64'(cnt_r);
   // Later of minimum delay, floor and inverse time
   // Equal delays make this a plain check at the operate delay
   assign trip_cond = avg_above && inv_due && (since_ms_r >= minimum_operate_delay_ms) && (since_ms_r >= floor_ms);

   assign pick_now = (state_r == ST_IDLE) && above && (qual_ms_r >= 7'(QUAL_MS));
   assign start_now = (state_r == ST_PICKED) && (since_ms_r >= 14'(START_DLY_MS));
   // Release needs stability and an expired delay without trip
   assign release_now = (stable_ms_r >= 7'(STABLE_MS))
      && ((state_r == ST_TRIP) || (state_r == ST_START && since_ms_r >= tset_ms && !trip_cond));

   // ------------------------------------------------------------
   // Stage state machine
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         state_r <= ST_IDLE;
      end
      else
      begin
         case (state_r)
            ST_IDLE:
            begin
               if (pick_now)
               begin
                  state_r <= ST_PICKED;
               end
            end
            ST_PICKED:
            begin
               if (start_now)
               begin
                  state_r <= ST_START;
               end
            end
            ST_START:
            begin
               if (trip_cond)
               begin
                  state_r <= ST_TRIP;
               end
               else if (release_now)
               begin
                  state_r <= ST_IDLE;
               end
            end
            ST_TRIP:
            begin
               if (release_now)
               begin
                  state_r <= ST_IDLE;
               end
            end
            default:
            begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   assign start_out = (state_r == ST_START) || (state_r == ST_TRIP);
   assign trip_out = (state_r == ST_TRIP);

   // ------------------------------------------------------------
   // Events
   // ------------------------------------------------------------
   // Gated one-cycle event pulses
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         start_on_evt <= 1'b0;
         start_off_evt <= 1'b0;
         trip_on_evt <= 1'b0;
         trip_off_evt <= 1'b0;
      end
      else
      begin
         start_on_evt <= start_now && ctrl_r[CTRL_EVT_LSB];
         start_off_evt <= release_now && ctrl_r[CTRL_EVT_LSB + 1];
         trip_on_evt <= (state_r == ST_START) && trip_cond && ctrl_r[CTRL_EVT_LSB + 2];
         trip_off_evt <= (state_r == ST_TRIP) && release_now && ctrl_r[CTRL_EVT_LSB + 3];
      end
   end

   // ------------------------------------------------------------
   // Counters and fault records
   // ------------------------------------------------------------
   // Start and trip counts; a count with a clear in the same cycle gives 1
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         start_cnt_r <= 32'h0;
         trip_cnt_r <= 32'h0;
      end
      else
      begin
         if (start_now)
         begin
            start_cnt_r <= (reg_wr && reg_addr == A_CMD && reg_wdata[CMD_CLR_START]) ? 32'h1 : start_cnt_r + 32'h1;
         end
         else if (reg_wr && reg_addr == A_CMD && reg_wdata[CMD_CLR_START])
         begin
            start_cnt_r <= 32'h0;
         end
         if (state_r == ST_START && trip_cond)
         begin
            trip_cnt_r <= (reg_wr && reg_addr == A_CMD && reg_wdata[CMD_CLR_TRIP]) ? 32'h1 : trip_cnt_r + 32'h1;
         end
         else if (reg_wr && reg_addr == A_CMD && reg_wdata[CMD_CLR_TRIP])
         begin
            trip_cnt_r <= 32'h0;
         end
      end
   end

   // Peak slope of the present or last fault
   always_ff @(posedge ref_clk)
   begin
      if (rst || pick_now)
      begin
         fault_max_r <= rst ? 32'h0 : abs_slope;
      end
      else if (state_r != ST_IDLE && abs_slope > fault_max_r)
      begin
         fault_max_r <= abs_slope;
      end
   end

   // Elapsed percent of operate delay, 100 on trip
   always_ff @(posedge ref_clk)
   begin
      if (rst || pick_now)
      begin
         pct_r <= 10'h0;
         pct_acc_r <= 14'h0;
      end
      else if (state_r == ST_START && trip_cond)
      begin
         pct_r <= PCT_TRIP;
      end
      else if (tick && (state_r == ST_PICKED || state_r == ST_START))
      begin
         if (pct_acc_r + 14'd100 >= tset_ms)
         begin
            pct_acc_r <= pct_acc_r + 14'd100 - tset_ms;
            pct_r <= (pct_r < PCT_MAX) ? pct_r + 10'h1 : pct_r;
         end
         else
         begin
            pct_acc_r <= pct_acc_r + 14'd100;
         end
      end
   end

   // ------------------------------------------------------------
   // Register port
   // ------------------------------------------------------------
   assign grp_hit = (reg_addr >= A_GROUP_BASE) && (reg_addr < A_GROUP_BASE + 8'(4 * GROUPS));
   assign grp_idx = GW'((reg_addr - A_GROUP_BASE) >> 2);

   // Setting writes clamped into their ranges
   function automatic logic [31:0] clamp_set(input logic [31:0] w);
      logic [6:0] s;
      logic [9:0] t;
      logic [9:0] m;
      s = w[SLOPE_LSB +: SLOPE_W];
      t = w[TSET_LSB +: DLY_W];
      m = w[MINIMUM_OPERATE_DELAY_LSB +: DLY_W];
      s = (s < SLOPE_MIN) ? SLOPE_MIN : ((s > SLOPE_MAX) ? SLOPE_MAX : s);
      t = (t < DLY_MIN) ? DLY_MIN : ((t > DLY_MAX) ? DLY_MAX : t);
      m = (m < DLY_MIN) ? DLY_MIN : ((m > t) ? t : m);
      return {2'h0, m, 2'h0, t, 1'h0, s};
   endfunction : clamp_set

   assign set_bus.wr_en = reg_wr && grp_hit;
   assign set_bus.wr_idx = grp_idx;
   assign set_bus.wr_data = clamp_set(reg_wdata);
   assign set_bus.rd_idx = grp_idx;

   // Control register write
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         ctrl_r <= CTRL_RST;
      end
      else if (reg_wr && reg_addr == A_CTRL)
      begin
         ctrl_r <= reg_wdata & 32'h0000_00f7;
      end
   end

   // Read data one cycle after the strobe
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         rdata_r <= 32'h0;
         rd_grp_r <= 1'b0;
      end
      else
      begin
         rd_grp_r <= reg_rd && grp_hit;
         if (!reg_rd)
         begin
            rdata_r <= 32'h0;
         end
         else if (reg_addr == A_CTRL)
         begin
            rdata_r <= ctrl_r;
         end
         else if (reg_addr == A_STATUS)
         begin
            rdata_r <= {26'h0, 2'(set_bus.act_idx), 1'b0, trip_out, start_out, state_r != ST_IDLE};
         end
         else if (reg_addr == A_FREQ)
         begin
            rdata_r <= {8'h0, freq_prev_r};
         end
         else if (reg_addr == A_SLOPE)
         begin
            rdata_r <= slope_r;
         end
         else if (reg_addr == A_START_CNT)
         begin
            rdata_r <= start_cnt_r;
         end
         else if (reg_addr == A_TRIP_CNT)
         begin
            rdata_r <= trip_cnt_r;
         end
         else if (reg_addr == A_FAULT)
         begin
            rdata_r <= fault_max_r;
         end
         else if (reg_addr == A_ELAPSED)
         begin
            rdata_r <= {22'h0, pct_r};
         end
         else
         begin
            rdata_r <= 32'h0;
         end
      end
   end

   assign reg_rdata = rd_grp_r ? set_bus.rd_data : rdata_r;

endmodule : rcf_stage
`default_nettype wire

// ---- dv/rcf_freq_src.sv ----
// Frequency source standing in for the measurement path.
// Assumes one clock shared with the stage.
`timescale 1ns/10ps
`default_nettype none
module rcf_freq_src #(
   parameter int PERIOD = 200
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Change per sample in mHz
   input wire logic signed [15:0] step,
   // Samples
   output logic freq_valid,
   output logic [23:0] freq_mhz
);
   int cnt;
   logic [23:0] f_r;
   // Fixed sample pacing
   always_ff @(posedge ref_clk)
      cnt <= (rst || cnt == PERIOD - 1) ? 0 : cnt + 1;
   // Ramp by step once per sample
   always_ff @(posedge ref_clk)
      f_r <= rst ? 24'h00c350 : (cnt == PERIOD - 1) ? f_r + 24'(step) : f_r;
   // Data scrambled outside the valid cycle
   assign freq_valid = !rst && cnt == PERIOD - 1;
   assign freq_mhz = freq_valid ? f_r : ~f_r;
endmodule : rcf_freq_src
`default_nettype wire

// ---- dv/rcf_stage_asserts.sv ----
// Output checker for the stage.
// Assumes it is bound to the stage top module.
`timescale 1ns/10ps
`default_nettype none
module rcf_stage_asserts #(
   parameter int CYC_PER_MS_P = 200000
)
(
   // Watched ports
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic start_out,
   input wire logic trip_out,
   input wire logic start_on_evt,
   input wire logic start_off_evt,
   input wire logic trip_on_evt,
   input wire logic trip_off_evt
);
   longint quiet_r;
   longint up_r;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Cycles with start low, and with start high
   always_ff @(posedge ref_clk)
      quiet_r <= (rst || start_out) ? 0 : quiet_r + 1;
   always_ff @(posedge ref_clk)
      up_r <= (rst || !start_out) ? 0 : up_r + 1;
   sequence s_evt(lvl, ev);
      (lvl && ev) ##1 (lvl && !ev);
   endsequence
   property p_rd_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
   property p_trip_start; trip_out |-> start_out; endproperty
   property p_start_qual; $rose(start_out) |-> quiet_r >= 139 * CYC_PER_MS_P; endproperty
   property p_trip_dly; $rose(trip_out) |-> up_r >= 79 * CYC_PER_MS_P; endproperty
   property p_son; start_on_evt |-> s_evt(start_out, start_on_evt); endproperty
   property p_ton; trip_on_evt |-> s_evt(trip_out, trip_on_evt); endproperty
   property p_soff; start_off_evt |-> !start_out; endproperty
   property p_toff; trip_off_evt |-> !trip_out && !start_out; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   a_trip_start: assert property (p_trip_start) else $error("trip without start");
   a_start_qual: assert property (p_start_qual) else $error("start too early");
   a_trip_dly: assert property (p_trip_dly) else $error("trip too early");
   a_son: assert property (p_son) else $error("bad start on pulse");
   a_ton: assert property (p_ton) else $error("bad trip on pulse");
   a_soff: assert property (p_soff) else $error("start off while started");
   a_toff: assert property (p_toff) else $error("trip off while active");
endmodule : rcf_stage_asserts
bind rcf_stage rcf_stage_asserts #(.CYC_PER_MS_P(CYC_PER_MS_P)) rcf_stage_asserts_i (.ref_clk(ref_clk),
   .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .start_out(start_out), .trip_out(trip_out),
   .start_on_evt(start_on_evt), .start_off_evt(start_off_evt), .trip_on_evt(trip_on_evt),
   .trip_off_evt(trip_off_evt));
`default_nettype wire

// ---- dv/rcf_stage_tb.sv ----
// Self-checking bench for the stage.
// Assumes the bound checker and a 20-cycle millisecond tick.
`timescale 1ns/10ps
`default_nettype none
module rcf_stage_tb
   import rcf_pkg::*;
;
   localparam int MS = 20;
   typedef struct {bit w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} rcf_reg_s;
   typedef struct {logic [6:0] sl; logic [9:0] t; logic [9:0] tm; logic signed [15:0] st; int dly;} rcf_row_s;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [1:0] group_pins = 2'h0;
   logic signed [15:0] step = 16'sh0;
   logic freq_valid, start_out, trip_out;
   logic [23:0] freq_mhz;
   logic [31:0] reg_rdata;
   logic [3:0] evt;
   int evt_n [4] = '{0, 0, 0, 0};
   int errors = 0;
   int n_tests = 0;
   rcf_reg_s regs [8] = '{'{0, A_CTRL, 0, CTRL_RST}, '{0, A_STATUS, 0, 0}, '{0, A_START_CNT, 0, 0},
      '{0, A_GROUP_BASE, 0, SET_DEF}, '{0, 8'h4c, 0, SET_DEF}, '{1, 8'h3c, 32'h1, 0},
      '{1, 8'h44, 32'h1, 32'h00e00e02}, '{1, 8'h44, 32'h3ff3ff7f, 32'h3e83e864}};
   rcf_row_s rows [3] = '{'{7'h0a, 10'h014, 10'h014, -16'sh14, 140 * MS},
      '{7'h0a, 10'h03c, 10'h00f, -16'sh14, 240 * MS}, '{7'h0a, 10'h03c, 10'h00f, 16'sh64, 90 * MS}};
   // ----
   // Design and frequency source
   // ----
   always #2.5 ref_clk = ~ref_clk;
   rcf_stage #(.CYC_PER_MS_P(MS)) rcf_stage_i (.ref_clk(ref_clk), .rst(rst), .freq_valid(freq_valid),
      .freq_mhz(freq_mhz), .group_pins(group_pins), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .start_out(start_out), .trip_out(trip_out),
      .start_on_evt(evt[3]), .start_off_evt(evt[2]), .trip_on_evt(evt[1]), .trip_off_evt(evt[0]));
   rcf_freq_src #(.PERIOD(10 * MS)) rcf_freq_src_i (.ref_clk(ref_clk), .rst(rst), .step(step),
      .freq_valid(freq_valid), .freq_mhz(freq_mhz));
   // Event pulse tallies
   always @(posedge ref_clk)
      foreach (evt_n[i])
         evt_n[i] += int'(evt[i] === 1'b1);
   task automatic finish_test();
      $display("checks %0d, errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask : rd
   task automatic wt(input bit sel, input logic lvl, output int n);
      for (n = 0; (sel ? trip_out : start_out) !== lvl; n++)
      begin
         @(posedge ref_clk);
         #1;
         if (n == 30000)
         begin
            errors++;
            finish_test();
         end
      end
   endtask : wt
   task automatic run(input rcf_row_s r);
      int d;
      wr(A_GROUP_BASE, {2'h0, r.tm, 2'h0, r.t, 1'h0, r.sl});
      step <= r.st;
      wt(0, 1'b1, d);
      rd(A_SLOPE, 32'(r.st * 16'sh0064));
      wt(1, 1'b1, d);
      chk(32'(d >= r.dly - 40 && d <= r.dly + 40), 32'h1);
      step <= 16'sh0;
      wt(0, 1'b0, d);
      rd(A_FAULT, 32'(r.st < 0 ? -r.st : r.st) * 32'd100);
      rd(A_ELAPSED, 32'h64);
   endtask : run
   // Main sequence
   initial
   begin
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      foreach (regs[i])
      begin
         if (regs[i].w)
            wr(regs[i].a, regs[i].d);
         rd(regs[i].a, regs[i].e);
      end
      foreach (rows[i])
         run(rows[i]);
      rd(A_START_CNT, 32'h3);
      rd(A_TRIP_CNT, 32'h3);
      foreach (evt_n[i])
         chk(evt_n[i], 32'h3);
      wr(A_CMD, 32'h1);
      rd(A_START_CNT, 32'h0);
      rd(A_TRIP_CNT, 32'h3);
      wr(A_CTRL, 32'h0);
      run(rows[0]);
      foreach (evt_n[i])
         chk(evt_n[i], 32'h3);
      rd(A_TRIP_CNT, 32'h4);
      group_pins <= 2'h1;
      wr(A_CTRL, 32'h4);
      rd(A_STATUS, 32'h10);
      rd(A_SLOPE, 32'h0);
      wr(A_CMD, 32'h2);
      rd(A_TRIP_CNT, 32'h0);
      finish_test();
   end
endmodule : rcf_stage_tb
`default_nettype wire
